// *** tb/modem_serial_register_port_asserts.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// port checks of the serial register port
// ----------------------------------------
module modem_serial_register_port_asserts (
    // clock and reset
    input logic mclk,
    input logic rst,
    // serial and interrupt pins
    input logic chip_select_n,
    input logic serial_clock,
    input logic reply_data,
    input logic reply_data_oe,
    input logic interrupt_request_n,
    input logic interrupt_request_n_oe,
    // register contents and derived controls
    input logic [7:0] line_setup,
    input logic [7:0] tone_control,
    input logic [7:0] interrupt_enable_mask,
    input logic transmit_byte_written,
    input logic normal_power,
    input logic inverted_tx_output,
    input logic relay_pull_low,
    input logic tone_output_on
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_IRQ_DRAIN: assert property (interrupt_request_n == 1'b0)
        else $error("interrupt pin data not low");
    AST_POWER_BIT: assert property (normal_power == line_setup[4])
        else $error("power state differs from setup bit 4");
    AST_INVERTED_TX_OUTPUT_GATE: assert property (inverted_tx_output == (line_setup[6] & line_setup[4]))
        else $error("inverted output not gated by power");
    AST_RELAY_BIT: assert property (relay_pull_low == line_setup[5])
        else $error("relay drive differs from setup bit 5");
    AST_TONE_GATE: assert property (tone_output_on == (tone_control[6] & normal_power))
        else $error("tone output not gated by power");
    AST_IRQ_MASKED: assert property (interrupt_request_n_oe |-> interrupt_enable_mask != 8'h00)
        else $error("interrupt asserted with no mask bit set");
    AST_RESERVED_ZERO: assert property ((tone_control & 8'h2E) == 8'h00 && (interrupt_enable_mask & 8'hC0) == 8'h00)
        else $error("reserved bit stored as one");
    // a reply bit may only move while the serial clock is low
    AST_REPLY_STEADY: assert property (serial_clock && $past(serial_clock, 2) && $past(reply_data_oe)
        && reply_data_oe |-> $stable(reply_data))
        else $error("reply bit moved while clock high");
    AST_REPLY_IDLE: assert property (chip_select_n [*5] |-> !reply_data_oe)
        else $error("reply pin driven outside a frame");
    AST_HOLD_IDLE: assert property (chip_select_n [*8] |=>
        $stable({line_setup, tone_control, interrupt_enable_mask}))
        else $error("register moved while deselected");
    AST_TX_PULSE: assert property (transmit_byte_written |=> !transmit_byte_written)
        else $error("transmit strobe longer than one cycle");
endmodule // modem_serial_register_port_asserts

bind modem_serial_register_port modem_serial_register_port_asserts
    modem_serial_register_port_asserts_i (.mclk, .rst, .chip_select_n, .serial_clock,
    .reply_data, .reply_data_oe, .interrupt_request_n, .interrupt_request_n_oe,
    .line_setup, .tone_control,
    .interrupt_enable_mask, .transmit_byte_written, .normal_power, .inverted_tx_output,
    .relay_pull_low, .tone_output_on);

// *** tb/serial_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// host side of the serial port
// ----------------------------------------
module serial_host_model (
    // clock
    input logic mclk,
    // pins toward the port
    output logic chip_select_n,
    output logic serial_clock,
    output logic command_data,
    // reply pin
    input logic reply_data,
    input logic reply_data_oe
);
    // idle: deselected, clock parked low
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        command_data = 1'b0;
    end
    // half a link period of 200 ns
    task automatic half();
        repeat (4) @(posedge mclk);
    endtask
    // nb bytes of clocks; rd turns the second byte into a reply
    task automatic frame(input logic [7:0] a, input logic [7:0] w, input int nb,
        input logic rd, output logic [7:0] q);
        logic [15:0] sh;
        sh = {a, w};
        q = 8'h00;
        chip_select_n <= 1'b0;
        half();
        for (int i = 0; i < 8 * nb; i++) begin
            command_data <= (i < 8 || !rd) ? sh[15 - i] : ~command_data;
            half();
            serial_clock <= 1'b1;
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            // capture late in the high phase; a released pin reads unknown
            if (i >= 8) q = {q[6:0], reply_data_oe ? reply_data : 1'bx};
            @(posedge mclk);
            serial_clock <= 1'b0;
        end
        half();
        chip_select_n <= 1'b1;
        command_data <= ~command_data;
        repeat (4) half();
    endtask
endmodule // serial_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`include "modem_serial_regs.vh"
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module testbench;
    logic mclk, rst, cs_n, sclk, cdat, rdat, roe, irq_oe, ring, sig, ld, bad, trdy, tund;
    logic txw, np, inv, rly, ton, p;
    logic [7:0] rxv, setup, tone, txb, modc, mask, r, v, n_tx;
    logic [7:0] ex [0:4];
    logic [7:0] ad [0:4] = '{`ADDR_LINE_SETUP, `ADDR_TONE_CONTROL, `ADDR_TRANSMIT_BYTE,
        `ADDR_MODULATION_CONTROL, `ADDR_INTERRUPT_MASK};
    int n_errors, tests_run, seed;

    modem_serial_register_port modem_serial_register_port_i (
        .mclk(mclk), .rst(rst), .chip_select_n(cs_n), .serial_clock(sclk),
        .command_data(cdat), .reply_data(rdat), .reply_data_oe(roe),
        .interrupt_request_n(), .interrupt_request_n_oe(irq_oe), .ring_detect(ring),
        .rx_signal_present(sig), .rx_byte_load(ld), .rx_byte_value(rxv),
        .rx_parity_bad(bad), .tx_ready_event(trdy), .tx_underflow_event(tund),
        .line_setup(setup), .tone_control(tone), .transmit_byte(txb),
        .modulation_control(modc), .interrupt_enable_mask(mask),
        .transmit_byte_written(txw), .normal_power(np), .inverted_tx_output(inv),
        .relay_pull_low(rly), .tone_output_on(ton));
    serial_host_model serial_host_model_i (.mclk(mclk), .chip_select_n(cs_n),
        .serial_clock(sclk), .command_data(cdat), .reply_data(rdat), .reply_data_oe(roe));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // count transmit byte strobes
    always @(posedge mclk) begin
        if (txw === 1'b1) n_tx <= n_tx + 8'h01;
    end

    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // what a write leaves in the register: reserved bits stay zero
    function automatic logic [7:0] keep(input logic [7:0] a, input logic [7:0] d);
        if (a == `ADDR_TONE_CONTROL) return d & `TONE_WRITABLE;
        if (a == `ADDR_INTERRUPT_MASK) return d & `MASK_WRITABLE;
        return d;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        serial_host_model_i.frame(a, d, 2, 1'b0, r);
        for (int j = 0; j < 5; j++)
            if (a == ad[j]) ex[j] = keep(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        serial_host_model_i.frame(a, 8'h00, 2, 1'b1, r);
        chk(r, e);
    endtask
    task automatic chk_regs();
        chk(setup, ex[0]);
        chk(tone, ex[1]);
        chk(txb, ex[2]);
        chk(modc, ex[3]);
        chk(mask, ex[4]);
    endtask
    task automatic ev(input logic l, input logic [7:0] d, input logic b, input logic t,
        input logic u);
        @(posedge mclk);
        ld <= l;
        rxv <= d;
        bad <= b;
        trdy <= t;
        tund <= u;
        @(posedge mclk);
        {ld, trdy, tund} <= 3'h0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic stop_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hD1AE8A63;
        n_errors = 0;
        tests_run = 0;
        n_tx = 8'h00;
        rst = 1'b1;
        {ring, sig, ld, bad, trdy, tund, rxv} = 14'h0;
        for (int j = 0; j < 5; j++) ex[j] = 8'h00;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_regs();
        rd(`ADDR_STATUS_FLAGS, 8'h00);
        // random writes, every sixth one to an unmapped address
        for (int k = 0; k < 12; k++) begin
            wr((k % 6 == 5) ? 8'hE5 : ad[k % 6], 8'($random(seed)));
            chk_regs();
        end
        chk(n_tx, 8'h02);
        wr(`ADDR_LINE_SETUP, ex[0] | 8'h10);
        wr(`ADDR_INTERRUPT_MASK, 8'hEF);
        p = ex[0][2];
        sig <= 1'b1;
        v = 8'($random(seed));
        ev(1'b1, 8'h5A, 1'b0, 1'b1, 1'b1);
        ev(1'b1, v, 1'b1, 1'b0, 1'b0);
        chk({7'h0, irq_oe}, 8'h01);
        rd(`ADDR_RECEIVE_BYTE, v);
        rd(`ADDR_STATUS_FLAGS, {p, 3'h1, 4'hF});
        chk({7'h0, irq_oe}, 8'h00);
        rd(`ADDR_STATUS_FLAGS, {p, 3'h1, 4'h0});
        chk_regs();
        ring <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({7'h0, irq_oe}, 8'h01);
        rd(`ADDR_STATUS_FLAGS, {p, 3'h7, 4'h0});
        ring <= 1'b0;
        rd(`ADDR_STATUS_FLAGS, {p, 3'h3, 4'h0});
        // zero power by the setup bit alone
        wr(`ADDR_LINE_SETUP, ex[0] & 8'hEF);
        chk_regs();
        chk({5'h0, np, inv, ton}, 8'h00);
        ev(1'b0, 8'h00, 1'b0, 1'b1, 1'b1);
        ring <= 1'b1;
        rd(`ADDR_STATUS_FLAGS, {p, 3'h6, 4'h0});
        wr(`ADDR_SOFT_RESET, 8'($random(seed)));
        chk_regs();
        serial_host_model_i.frame(`ADDR_SOFT_RESET, 8'h00, 1, 1'b0, r);
        for (int j = 0; j < 5; j++) ex[j] = 8'h00;
        chk_regs();
        rd(`ADDR_STATUS_FLAGS, {p, 3'h4, 4'h0});
        wr(`ADDR_TONE_CONTROL, 8'hBF);
        wr(`ADDR_LINE_SETUP, 8'h70);
        chk({5'h0, np, inv, rly}, 8'h07);
        chk({7'h0, ton}, 8'h00);
        chk_regs();
        // detector mask holds the interrupt only while the signal lasts
        wr(`ADDR_INTERRUPT_MASK, 8'h10);
        chk(mask, 8'h10);
        chk({7'h0, irq_oe}, 8'h01);
        sig <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({7'h0, irq_oe}, 8'h00);
        stop_test();
    end
    // watchdog: the sequence needs well under a millisecond
    initial begin
        #2_000_000;
        n_errors++;
        stop_test();
    end
endmodule // testbench

// *** verilog/modem_serial_register_port.v ***
// How it works
// - each frame: one address byte, then nothing, one write byte or one reply byte
// - command bits are sampled on rising serial clock edges
// - first reply bit driven on the last address rising edge, later bits change after falling edges, so stay steady while clock is high
// - write addresses take one byte, read addresses return one byte
// - address-only frame to soft reset clears write registers and flags 0-3 and 5, zero power
// - setup bit 4 low powers down all but serial port, ring detector and relay drive
// - clearing setup bit 4 directly leaves all other bits alone
// - interrupt pulled low when flag 0-3 or 5 set with its mask bit
// - flag 5 set on any change of ring level
// - status read clears flags 0-3 and 5 after return, releasing interrupt
// - flag 4 follows the detector level and is not cleared by reads
// - mask bit 4 holds interrupt low while signal is present
// - setup register fields control standard, outputs, power and framing
// - tone control fields, reserved bits kept at zero
// - modulation control fields drive modem receive and transmit modes
// - status flag layout; reserved mask bits 7 and 6 held zero
// - ring detector level appears as flag 6
// - new receive byte sets flag 2, and flag 3 if previous unread
`timescale 1ns/1ns
`include "modem_serial_regs.vh"

module modem_serial_register_port (
    // clock and reset
    input wire mclk,
    input wire rst,
    // serial host pins
    input wire chip_select_n,
    input wire serial_clock,
    input wire command_data,
    output reg reply_data,
    output wire reply_data_oe,
    // open-drain interrupt pin
    output wire interrupt_request_n,
    output wire interrupt_request_n_oe,
    // ring detector level, asynchronous
    input wire ring_detect,
    // modem core events and levels, mclk domain
    input wire rx_signal_present,
    input wire rx_byte_load,
    input wire [7:0] rx_byte_value,
    input wire rx_parity_bad,
    input wire tx_ready_event,
    input wire tx_underflow_event,
    // register contents toward the modem core
    output reg [7:0] line_setup,
    output reg [7:0] tone_control,
    output reg [7:0] transmit_byte,
    output reg [7:0] modulation_control,
    output reg [7:0] interrupt_enable_mask,
    output reg transmit_byte_written,
    output wire normal_power,
    output wire inverted_tx_output,
    output wire relay_pull_low,
    output wire tone_output_on
);

    // ---------------------------------------------------------------
    // transaction states
    // ---------------------------------------------------------------
    localparam ST_ADDR = 2'd0;
    localparam ST_WDATA = 2'd1;
    localparam ST_RDATA = 2'd2;
    localparam ST_SKIP = 2'd3;

    wire [3:0] pins_s;
    wire cs_n_s;
    wire sclk_s;
    wire cmd_s;
    wire ring_s;
    wire frame_active;
    wire sclk_rise;
    wire sclk_fall;

    reg [1:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [6:0] shift_in_r;
    reg [7:0] addr_r;
    reg [7:0] reply_sr_r;
    reg reply_oe_r;
    reg [7:0] read_snap_r;
    reg cs_n_prev_r;
    reg [7:0] flags_r;
    reg ring_prev_r;
    reg rx_unread_r;
    reg [7:0] receive_byte_r;

    wire [7:0] byte_in;
    wire is_read_addr;
    wire frame_end;
    wire soft_reset;
    wire write_now;
    wire read_done;
    wire [7:0] status_value;
    wire [7:0] flag_set;
    wire [7:0] flag_clr;
    wire [7:0] flags_nxt;
    wire powered;
    wire irq_active;

    // ---------------------------------------------------------------
    // pin synchronisers and serial clock edges
    // ---------------------------------------------------------------
    pin_sync #(
        .WIDTH(4),
        // ring idles low, so leaving reset shows no false ring change
        .RESET_VALUE(4'h7)
    ) u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in({ring_detect, command_data, serial_clock, chip_select_n}),
        .pin_sync_out(pins_s)
    );

    assign cs_n_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign cmd_s = pins_s[2];
    assign ring_s = pins_s[3];
    assign frame_active = ~cs_n_s;

    serial_edges u_serial_edges (
        .mclk(mclk),
        .rst(rst),
        .sclk_s(sclk_s),
        .frame_active(frame_active),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall)
    );

    // ---------------------------------------------------------------
    // frame decode
    // ---------------------------------------------------------------
    // assembled byte on its eighth rising edge, msb arrived first
    assign byte_in = {shift_in_r, cmd_s};
    assign is_read_addr = (byte_in == `ADDR_RECEIVE_BYTE) |
                          (byte_in == `ADDR_STATUS_FLAGS);
    assign frame_end = cs_n_s & ~cs_n_prev_r;
    // soft reset only when the frame closed right after its address byte
    assign soft_reset = frame_end & (state_r == ST_WDATA) &
                        (bit_cnt_r == 4'h0) & (addr_r == `ADDR_SOFT_RESET);
    assign write_now = sclk_rise & (state_r == ST_WDATA) &
                       (bit_cnt_r == `BIT_COUNT_LAST);
    assign read_done = sclk_fall & (state_r == ST_RDATA) &
                       (bit_cnt_r == `BITS_PER_BYTE) & ~cs_n_s;

    // ---------------------------------------------------------------
    // serial transaction engine
    // ---------------------------------------------------------------
    // a frame that ends early simply restarts at the address byte
    always @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            shift_in_r <= 7'h00;
            addr_r <= 8'h00;
            reply_sr_r <= 8'h00;
            reply_oe_r <= 1'b0;
            reply_data <= 1'b0;
            read_snap_r <= 8'h00;
            cs_n_prev_r <= 1'b1;
        end else begin
            cs_n_prev_r <= cs_n_s;
            if (cs_n_s) begin
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                reply_oe_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR: begin
                        if (sclk_rise) begin
                            shift_in_r <= byte_in[6:0];
                            if (bit_cnt_r == `BIT_COUNT_LAST) begin
                                addr_r <= byte_in;
                                bit_cnt_r <= 4'h0;
                                if (is_read_addr) begin
                                    // first reply bit shown at once, ready for next high
                                    state_r <= ST_RDATA;
                                    reply_oe_r <= 1'b1;
                                    if (byte_in == `ADDR_STATUS_FLAGS) begin
                                        reply_data <= status_value[7];
                                        reply_sr_r <= {status_value[6:0], 1'b0};
                                        read_snap_r <= status_value;
                                    end else begin
                                        reply_data <= receive_byte_r[7];
                                        reply_sr_r <= {receive_byte_r[6:0], 1'b0};
                                        read_snap_r <= 8'h00;
                                    end
                                end else begin
                                    state_r <= ST_WDATA;
                                end
                            end else begin
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclk_rise) begin
                            shift_in_r <= byte_in[6:0];
                            if (bit_cnt_r == `BIT_COUNT_LAST) begin
                                state_r <= ST_SKIP;
                                bit_cnt_r <= 4'h0;
                            end else begin
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (sclk_rise && bit_cnt_r != `BITS_PER_BYTE) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        // change only on falls so the bit is steady through the high phase
                        if (sclk_fall && bit_cnt_r != 4'h0) begin
                            if (bit_cnt_r == `BITS_PER_BYTE) begin
                                state_r <= ST_SKIP;
                                reply_oe_r <= 1'b0;
                            end else begin
                                reply_data <= reply_sr_r[7];
                                reply_sr_r <= {reply_sr_r[6:0], 1'b0};
                            end
                        end
                    end
                    ST_SKIP: begin
                        // extra clocks in the frame are ignored
                        bit_cnt_r <= 4'h0;
                    end
                    default: begin
                        state_r <= ST_ADDR;
                    end
                endcase
            end
        end
    end

    assign reply_data_oe = reply_oe_r;

    // ---------------------------------------------------------------
    // write registers
    // ---------------------------------------------------------------
    // only write addresses reach here, so reads leave these untouched
    always @(posedge mclk) begin
        if (rst || soft_reset) begin
            line_setup <= `WREG_RESET;
            tone_control <= `WREG_RESET;
            transmit_byte <= `WREG_RESET;
            modulation_control <= `WREG_RESET;
            interrupt_enable_mask <= `WREG_RESET;
            transmit_byte_written <= 1'b0;
        end else begin
            transmit_byte_written <= 1'b0;
            if (write_now) begin
                case (addr_r)
                    `ADDR_LINE_SETUP: line_setup <= byte_in;
                    `ADDR_TONE_CONTROL: tone_control <= byte_in & `TONE_WRITABLE;
                    `ADDR_TRANSMIT_BYTE: begin
                        transmit_byte <= byte_in;
                        transmit_byte_written <= 1'b1;
                    end
                    `ADDR_MODULATION_CONTROL: modulation_control <= byte_in;
                    `ADDR_INTERRUPT_MASK: begin
                        interrupt_enable_mask <= byte_in & `MASK_WRITABLE;
                    end
                    default: begin
                        // unknown address: nothing stored
                        transmit_byte <= transmit_byte;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // setup fields toward the core
    // ---------------------------------------------------------------
    assign normal_power = line_setup[`SETUP_NORMAL_POWER];
    assign inverted_tx_output = line_setup[`SETUP_INV_TX_OUT] & powered;
    assign relay_pull_low = line_setup[`SETUP_RELAY_LOW];
    // transmitter stays quiet in zero power whatever the tone bit says
    assign tone_output_on = tone_control[`TONE_OUTPUT_ON] & powered;
    assign powered = normal_power;

    // ---------------------------------------------------------------
    // receive byte holding register
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            receive_byte_r <= 8'h00;
            rx_unread_r <= 1'b0;
        end else begin
            if (rx_byte_load && powered) begin
                receive_byte_r <= rx_byte_value;
                rx_unread_r <= 1'b1; // set wins over a read finishing now
            end else if (read_done && addr_r == `ADDR_RECEIVE_BYTE) begin
                rx_unread_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    // core events are gated in zero power because those blocks are off
    assign flag_set[`FLAG_TX_READY] = tx_ready_event & powered;
    assign flag_set[`FLAG_TX_UNDERFLOW] = tx_underflow_event & powered;
    assign flag_set[`FLAG_RX_READY] = rx_byte_load & powered;
    assign flag_set[`FLAG_RX_OVERFLOW] = rx_byte_load & powered & rx_unread_r;
    assign flag_set[`FLAG_RX_ENERGY] = 1'b0;
    assign flag_set[`FLAG_RING_CHANGE] = ring_s ^ ring_prev_r;
    assign flag_set[`FLAG_RING_LEVEL] = 1'b0;
    assign flag_set[`FLAG_BAD_PARITY] = 1'b0;

    // a read clears only what it returned, so later events survive
    assign flag_clr = (soft_reset ? `FLAG_READ_CLEARED : 8'h00) |
                      ((read_done && addr_r == `ADDR_STATUS_FLAGS) ?
                       (read_snap_r & `FLAG_READ_CLEARED) : 8'h00);
    assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

    always @(posedge mclk) begin
        if (rst) begin
            flags_r <= 8'h00;
            ring_prev_r <= 1'b0;
        end else begin
            ring_prev_r <= ring_s;
            flags_r <= flags_nxt & `FLAG_READ_CLEARED;
            // parity flag tracks each new byte, reads leave it alone
            if (rx_byte_load && powered) begin
                flags_r[`FLAG_BAD_PARITY] <= rx_parity_bad &
                                             line_setup[`SETUP_PARITY_EN];
            end else begin
                flags_r[`FLAG_BAD_PARITY] <= flags_r[`FLAG_BAD_PARITY];
            end
        end
    end

    // live levels merged into the readable value
    assign status_value = {flags_r[`FLAG_BAD_PARITY], ring_s,
                           flags_r[`FLAG_RING_CHANGE],
                           rx_signal_present & powered,
                           flags_r[3:0]};

    // ---------------------------------------------------------------
    // interrupt request
    // ---------------------------------------------------------------
    assign irq_active = |(flags_r & interrupt_enable_mask & `FLAG_READ_CLEARED) |
                        (interrupt_enable_mask[`FLAG_RX_ENERGY] &
                         status_value[`FLAG_RX_ENERGY]);
    assign interrupt_request_n = 1'b0;
    assign interrupt_request_n_oe = irq_active;

endmodule // modem_serial_register_port

// *** verilog/modem_serial_regs.vh ***
`ifndef MODEM_SERIAL_REGS_VH
`define MODEM_SERIAL_REGS_VH

// ---------------------------------------------------------------
// register addresses, as carried in the first byte of a transaction
// ---------------------------------------------------------------
`define ADDR_SOFT_RESET 8'h01
`define ADDR_LINE_SETUP 8'hE0
`define ADDR_TONE_CONTROL 8'hE1
`define ADDR_TRANSMIT_BYTE 8'hE3
`define ADDR_MODULATION_CONTROL 8'hE7
`define ADDR_RECEIVE_BYTE 8'hEA
`define ADDR_INTERRUPT_MASK 8'hEE
`define ADDR_STATUS_FLAGS 8'hEF

// ---------------------------------------------------------------
// reset values, writable-bit masks and the read-cleared flag mask
// ---------------------------------------------------------------
`define WREG_RESET 8'h00
`define TONE_WRITABLE 8'hD1
`define MASK_WRITABLE 8'h3F
`define FLAG_READ_CLEARED 8'h2F

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SETUP_FSK_STANDARD 7
`define SETUP_INV_TX_OUT 6
`define SETUP_RELAY_LOW 5
`define SETUP_NORMAL_POWER 4
`define SETUP_TWO_STOP 3
`define SETUP_PARITY_EN 2
`define SETUP_PARITY_EVEN 1
`define SETUP_SEVEN_BITS 0
`define TONE_TONES_SEL 7
`define TONE_OUTPUT_ON 6
`define TONE_SINGLE 4
`define TONE_DETECT_2100 0
`define FLAG_BAD_PARITY 7
`define FLAG_RING_LEVEL 6
`define FLAG_RING_CHANGE 5
`define FLAG_RX_ENERGY 4
`define FLAG_RX_OVERFLOW 3
`define FLAG_RX_READY 2
`define FLAG_TX_UNDERFLOW 1
`define FLAG_TX_READY 0

// ---------------------------------------------------------------
// serial frame
// ---------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define BIT_COUNT_LAST 4'h7

`endif

// *** verilog/pin_sync.v ***
`timescale 1ns/1ns

// two-flop synchroniser for pins from outside the mclk domain
module pin_sync #(
    parameter WIDTH = 4,
    // level held in reset, matching each pin's idle level
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // asynchronous pins and their synchronised copies
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    // the first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge mclk) begin
                if (rst) begin
                    meta_r[i] <= RESET_VALUE[i];
                    stable_r[i] <= RESET_VALUE[i];
                end else begin
                    meta_r[i] <= pin_in[i];
                    stable_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign pin_sync_out = stable_r;

endmodule // pin_sync

// *** verilog/serial_edges.v ***
`timescale 1ns/1ns

// finds edges of the synchronised serial clock inside a frame
module serial_edges (
    // clock and reset
    input wire mclk,
    input wire rst,
    // synchronised serial clock and frame level
    input wire sclk_s,
    input wire frame_active,
    // one-cycle edge pulses
    output wire sclk_rise,
    output wire sclk_fall
);

    reg sclk_prev_r;

    // history tracked always so a frame opening with clock high sees no edge
    always @(posedge mclk) begin
        if (rst) begin
            sclk_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
        end
    end

    assign sclk_rise = frame_active & sclk_s & ~sclk_prev_r;
    assign sclk_fall = frame_active & ~sclk_s & sclk_prev_r;

endmodule // serial_edges
